// [hdl/ttr_pkg.sv]
// shared constants and types for the timer trigger, repeat and direction block
package ttr_pkg;

	// ------------------------------------------------------------
	// bus and register map
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 16;
	localparam int          DATA_W      = 32;
	localparam logic [15:0] OFS_TRIG_SEL = 16'h18B0;
	localparam logic [15:0] OFS_REP_CNT  = 16'h18B4;
	localparam logic [15:0] OFS_REP_RLD  = 16'h18B8;
	localparam logic [15:0] OFS_QUAD_DIR = 16'h18BC;
	localparam logic [31:0] RST_REG     = 32'h00000000;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int          TRIG_EN_BIT = 9;
	localparam int          SEL_W       = 5;
	localparam int          REP_W       = 8;
	localparam int          DIR_BIT     = 0;
	localparam logic [4:0]  CODE_SUB0   = 5'h10;
	localparam logic [4:0]  CODE_SUB1   = 5'h11;
	localparam int          N_TIM_TRIG  = 16;
	localparam int          N_SUB       = 2;

	// ------------------------------------------------------------
	// suppressible events: load, zero, compare up/down, normal/shadow
	// ------------------------------------------------------------
	localparam int          N_EVT       = 6;
	localparam int          EVT_LOAD    = 0;
	localparam int          EVT_ZERO    = 1;
	localparam int          EVT_CMP_UP  = 2;
	localparam int          EVT_CMP_DN  = 3;
	localparam int          EVT_SHD_UP  = 4;
	localparam int          EVT_SHD_DN  = 5;

	// register and bus-answer state of the top module
	typedef struct packed {
		logic              trg_en;
		logic [SEL_W-1:0]  sel;
		logic [REP_W-1:0]  rld;
		logic [REP_W-1:0]  rep_cnt;
		logic [N_EVT-1:0]  evo;
		logic [DATA_W-1:0] rdata;
		logic              rdy;
		logic              err;
	} ttr_top_state_type;

endpackage : ttr_pkg

// [hdl/ttr_sub_if.sv]
// carrier between the top module and its trigger mux and direction decoder
`timescale 1ns/10ps
interface ttr_sub_if;
	logic [4:0]  sel;
	logic        trg_en;
	logic [15:0] tim_trig;
	logic [1:0]  sub_evt;
	logic        trig;
	logic        qen;
	logic        qa;
	logic        qb;
	logic        dir;

	modport top  (output sel, trg_en, tim_trig, sub_evt, qen, qa, qb, input trig, dir);
	modport mux  (input sel, trg_en, tim_trig, sub_evt, output trig);
	modport qdec (input qen, qa, qb, output dir);
endinterface : ttr_sub_if

// [hdl/ttr_trig_mux.sv]
// trigger source selection, registered
`timescale 1ns/10ps
module ttr_trig_mux
	import ttr_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	ttr_sub_if.mux    s
);
	typedef struct packed {
		logic trig;
	} ttr_mux_state_type;

	ttr_mux_state_type st_q;
	ttr_mux_state_type st_d;

	// pick the enabled source; reserved codes give no trigger
	always_comb begin
		st_d = '0;
		if (s.trg_en) begin
			if (s.sel < CODE_SUB0) begin
				st_d.trig = s.tim_trig[s.sel[3:0]];
			end else if (s.sel == CODE_SUB0) begin
				st_d.trig = s.sub_evt[0];
			end else if (s.sel == CODE_SUB1) begin
				st_d.trig = s.sub_evt[1];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign s.trig = st_q.trig;
endmodule : ttr_trig_mux

// [hdl/ttr_quad_dir.sv]
// count direction from two quadrature phases
`timescale 1ns/10ps
module ttr_quad_dir
	import ttr_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	ttr_sub_if.qdec   s
);
	typedef struct packed {
		logic a;
		logic b;
		logic dir;
	} ttr_qd_state_type;

	ttr_qd_state_type st_q;
	ttr_qd_state_type st_d;

	// an edge on a phase tells which one leads
	always_comb begin
		st_d     = st_q;
		st_d.a   = s.qa;
		st_d.b   = s.qb;
		if (s.qen) begin
			if (s.qa != st_q.a) begin
				st_d.dir = (s.qa != s.qb);
			end else if (s.qb != st_q.b) begin
				st_d.dir = (s.qb == s.qa);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign s.dir = st_q.dir;
endmodule : ttr_quad_dir

// [hdl/ttr_top.sv]
// trigger selection, repeat counter and direction flag with an apb slave
//
// Overview of operation
// - enable bit 9 gates every trigger
// - five-bit selector picks the trigger line
// - codes 0-15 take other timer triggers
// - codes 16 and 17 take subscriber ports
// - codes 18-31 reserved, give no trigger
// - repeat counter suppresses load, compare, zero events
// - repeat count readable in bits 7-0
// - load at zero count copies reload value
// - direction bit: 1 up, 0 down
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module ttr_top
	import ttr_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [15:0]       timer_trig,
	input  wire logic [1:0]        sub_evt,
	input  wire logic              quadrature_decoder_mode,
	input  wire logic              phase_a,
	input  wire logic              phase_b,
	input  wire logic [N_EVT-1:0]  evt_in,
	output logic [N_EVT-1:0]       evt_out,
	output logic                   counter_trig,
	output logic                   quadrature_direction
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	// true for any of the four mapped words
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == OFS_TRIG_SEL) || (a == OFS_REP_CNT) ||
		           (a == OFS_REP_RLD) || (a == OFS_QUAD_DIR);
	endfunction : addr_hit

	ttr_top_state_type st_q;
	ttr_top_state_type st_d;
	ttr_sub_if         sub ();
	logic              wr_go;
	logic              rd_cap;
	logic [DATA_W-1:0] rd_mux;

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------

	// feed the trigger mux and the decoder from registers and pins
	assign sub.sel      = st_q.sel;
	assign sub.trg_en   = st_q.trg_en;
	assign sub.tim_trig = timer_trig;
	assign sub.sub_evt  = sub_evt;
	assign sub.qen      = quadrature_decoder_mode;
	assign sub.qa       = phase_a;
	assign sub.qb       = phase_b;

	ttr_trig_mux u_mux (
		.pclk    (pclk),
		.presetn (presetn),
		.s       (sub.mux)
	);

	ttr_quad_dir u_quadrature_direction (
		.pclk    (pclk),
		.presetn (presetn),
		.s       (sub.qdec)
	);

	// ------------------------------------------------------------
	// apb handshake and read mux
	// ------------------------------------------------------------

	// one wait state so that read data comes from a flop
	assign rd_cap = psel && penable && !st_q.rdy;
	assign wr_go  = psel && penable && st_q.rdy && pwrite && addr_hit(paddr);

	// reserved bits read as zero
	always_comb begin
		rd_mux = '0;
		if (paddr == OFS_TRIG_SEL) begin
			rd_mux[TRIG_EN_BIT] = st_q.trg_en;
			rd_mux[SEL_W-1:0]   = st_q.sel;
		end else if (paddr == OFS_REP_CNT) begin
			rd_mux[REP_W-1:0]   = st_q.rep_cnt;
		end else if (paddr == OFS_REP_RLD) begin
			rd_mux[REP_W-1:0]   = st_q.rld;
		end else if (paddr == OFS_QUAD_DIR) begin
			rd_mux[DIR_BIT]     = sub.dir;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d     = st_q;
		st_d.rdy = rd_cap;
		if (rd_cap) begin
			st_d.rdata = pwrite ? '0 : rd_mux;
			st_d.err   = !addr_hit(paddr);
		end else begin
			st_d.err   = 1'b0;
		end
		// writes to read-only words are dropped quietly
		if (wr_go && paddr == OFS_TRIG_SEL) begin
			st_d.trg_en = pwdata[TRIG_EN_BIT];
			st_d.sel    = pwdata[SEL_W-1:0];
		end
		if (wr_go && paddr == OFS_REP_RLD) begin
			st_d.rld = pwdata[REP_W-1:0];
		end
		if (evt_in[EVT_LOAD] && st_q.rep_cnt == '0) begin
			st_d.rep_cnt = st_q.rld;
		end else if (evt_in[EVT_LOAD]) begin
			st_d.rep_cnt = st_q.rep_cnt - 8'h01;
		end
		// events pass only in the zero period
		st_d.evo = (st_q.rep_cnt == '0) ? evt_in : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flops
	// ------------------------------------------------------------
	assign prdata               = st_q.rdata;
	assign pready               = st_q.rdy;
	assign pslverr              = st_q.err;
	assign evt_out              = st_q.evo;
	assign counter_trig         = sub.trig;
	assign quadrature_direction = sub.dir;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_trig_gate_off: assert property (
		!st_q.trg_en |=> !counter_trig
	) else $error("trigger seen while triggers disabled");

	chk_trig_timer_sel: assert property (
		(st_q.trg_en && st_q.sel < CODE_SUB0 && timer_trig[st_q.sel[3:0]]) |=> counter_trig
	) else $error("selected timer trigger not passed");

	chk_trig_timer_low: assert property (
		(st_q.trg_en && st_q.sel < CODE_SUB0 && !timer_trig[st_q.sel[3:0]]) |=> !counter_trig
	) else $error("unselected timer line made a trigger");

	chk_trig_sub_port: assert property (
		(st_q.trg_en && st_q.sel == CODE_SUB1) |=> counter_trig == $past(sub_evt[1])
	) else $error("subscriber trigger not routed");

	chk_trig_sub_zero: assert property (
		(st_q.trg_en && st_q.sel == CODE_SUB0) |=> counter_trig == $past(sub_evt[0])
	) else $error("first subscriber trigger not routed");

	chk_trig_reserved_code: assert property (
		(st_q.trg_en && st_q.sel > CODE_SUB1) |=> !counter_trig
	) else $error("reserved code produced a trigger");

	chk_sel_write_store: assert property (
		(psel && penable && pready && pwrite && paddr == OFS_TRIG_SEL)
		|=> st_q.sel == $past(pwdata[4:0]) && st_q.trg_en == $past(pwdata[9])
	) else $error("selector write not stored");

	// the selector must not drift between writes, or triggers would hop sources
	chk_sel_no_write: assert property (
		!(psel && penable && pready && pwrite && paddr == OFS_TRIG_SEL)
		|=> st_q.sel == $past(st_q.sel)
	) else $error("selector changed without a write");

	chk_sel_read_back: assert property (
		(psel && penable && !pwrite && paddr == OFS_TRIG_SEL && !pready)
		|=> prdata == {22'h000000, $past(st_q.trg_en), 4'h0, $past(st_q.sel)}
	) else $error("selector readback wrong");

	chk_rep_reload_zero: assert property (
		(evt_in[EVT_LOAD] && st_q.rep_cnt == 8'h00) |=> st_q.rep_cnt == $past(st_q.rld)
	) else $error("reload value not copied at zero");

	chk_rld_write_store: assert property (
		(psel && penable && pready && pwrite && paddr == OFS_REP_RLD)
		|=> st_q.rld == $past(pwdata[7:0])
	) else $error("reload write not stored");

	chk_rld_read_back: assert property (
		(psel && penable && !pwrite && paddr == OFS_REP_RLD && !pready)
		|=> prdata == {24'h000000, $past(st_q.rld)}
	) else $error("reload readback wrong");

	chk_rep_step_down: assert property (
		(evt_in[EVT_LOAD] && st_q.rep_cnt != 8'h00)
		|=> st_q.rep_cnt == $past(st_q.rep_cnt) - 8'h01
	) else $error("repeat count did not step down");

	// software has no path into the count; only load events move it
	chk_cnt_hold_idle: assert property (
		!evt_in[EVT_LOAD] |=> st_q.rep_cnt == $past(st_q.rep_cnt)
	) else $error("repeat count moved without a load");

	chk_evt_suppress_run: assert property (
		(st_q.rep_cnt != 8'h00) |=> evt_out == 6'h00
	) else $error("event leaked while count nonzero");

	chk_evt_idle_quiet: assert property (
		(evt_in == 6'h00) |=> evt_out == 6'h00
	) else $error("event out without an event in");

	chk_evt_pass_zero: assert property (
		(st_q.rep_cnt == 8'h00) |=> evt_out == $past(evt_in)
	) else $error("event lost in zero period");

	chk_cnt_read_back: assert property (
		(psel && penable && !pwrite && paddr == OFS_REP_CNT && !pready)
		|=> pready && prdata == {24'h000000, $past(st_q.rep_cnt)}
	) else $error("repeat count readback wrong");

	// ------------------------------------------------------------
	// bus answer and direction checks
	// ------------------------------------------------------------

	// a second ready cycle would complete the next setup too early
	chk_ready_one_cycle: assert property (
		pready |=> !pready
	) else $error("ready held longer than one cycle");

	chk_ready_after_wait: assert property (
		(psel && penable && !pready) |=> pready
	) else $error("ready missing after the wait state");

	chk_err_with_ready: assert property (
		pslverr |-> pready
	) else $error("error shown outside a ready cycle");

	chk_err_unmapped: assert property (
		(psel && penable && !pready && !addr_hit(paddr)) |=> pslverr
	) else $error("unmapped access not flagged");

	chk_err_mapped_clear: assert property (
		(psel && penable && !pready && addr_hit(paddr)) |=> !pslverr
	) else $error("mapped access flagged as error");

	chk_write_data_zero: assert property (
		(psel && penable && !pready && pwrite) |=> prdata == 32'h00000000
	) else $error("read data not zero on a write");

	chk_dir_read_back: assert property (
		(psel && penable && !pwrite && paddr == OFS_QUAD_DIR && !pready)
		|=> prdata == {31'h00000000, $past(quadrature_direction)}
	) else $error("direction readback wrong");

	chk_dir_hold_off: assert property (
		!quadrature_decoder_mode |=> quadrature_direction == $past(quadrature_direction)
	) else $error("direction changed with decoder off");

	chk_dir_up_edge: assert property (
		(quadrature_decoder_mode && !phase_a && !phase_b)
		##1 (quadrature_decoder_mode && phase_a && !phase_b) |=> quadrature_direction
	) else $error("phase a leading not seen as up");

	chk_dir_down_edge: assert property (
		(quadrature_decoder_mode && !phase_a && !phase_b)
		##1 (quadrature_decoder_mode && !phase_a && phase_b) |=> !quadrature_direction
	) else $error("phase b leading not seen as down");

	// main scenarios
	cov_reload_taken:  cover property (evt_in[EVT_LOAD] && st_q.rep_cnt == 8'h00 && st_q.rld != 8'h00);
	cov_evt_held_back: cover property (st_q.rep_cnt != 8'h00 && evt_in != 6'h00);
	cov_sub_trigger:   cover property (st_q.trg_en && st_q.sel == CODE_SUB0 ##1 counter_trig);
	cov_dir_down:      cover property (quadrature_direction ##1 !quadrature_direction);
	cov_bad_address:   cover property (pready && pslverr);

endmodule : ttr_top

// [dv/ttr_far_model.sv]
// far side: other timers, subscriber ports, event source and encoder phases
`timescale 1ns/10ps
module ttr_far_model (
	input  wire logic pclk,
	output logic [15:0] timer_trig,
	output logic [1:0]  sub_evt,
	output logic [5:0]  evt_in,
	output logic        phase_a,
	output logic        phase_b
);
	// all lines idle low from time zero
	initial begin
		{sub_evt, timer_trig} = 18'h00000;
		evt_in = 6'h00;
		{phase_a, phase_b} = 2'b00;
	end
	// lines hold until changed, like real trigger outputs
	task automatic set_lines(input logic [17:0] v);
		@(posedge pclk);
		{sub_evt, timer_trig} <= v;
	endtask : set_lines
	// one-cycle event pulse, as the counter core makes them
	task automatic pulse_evt(input logic [5:0] v);
		@(posedge pclk);
		evt_in <= v;
		@(posedge pclk);
		evt_in <= 6'h00;
	endtask : pulse_evt
	// one encoder step held for a full cycle so it is always seen
	task automatic step(input logic a, input logic b);
		@(posedge pclk);
		phase_a <= a;
		phase_b <= b;
		@(posedge pclk);
	endtask : step
endmodule : ttr_far_model

// [dv/tb_top.sv]
// self-checking bench for the trigger, repeat and direction block
`timescale 1ns/10ps
`define CHK(n, x, y) begin compares++; if ((y) !== (x)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, x, y); end end
module tb_top
	import ttr_pkg::*;
();
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, q;
	logic [15:0]       timer_trig;
	logic [1:0]        sub_evt;
	logic [N_EVT-1:0]  evt_in, evt_out;
	logic              quadrature_decoder_mode, phase_a, phase_b;
	logic              counter_trig, quadrature_direction;
	int                n_mismatch, compares;

	ttr_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .timer_trig, .sub_evt, .quadrature_decoder_mode, .phase_a,
		.phase_b, .evt_in, .evt_out, .counter_trig, .quadrature_direction);
	ttr_far_model far (.pclk, .timer_trig, .sub_evt, .evt_in, .phase_a, .phase_b);

	// 40 MHz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// bus and closing tasks
	// ------------------------------------------------------------
	// request held until pready is seen high at a rising edge; data taken there
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20) n_mismatch++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// reset values, unmapped place
	task automatic t_reset;
		logic [15:0] a [4] = '{OFS_TRIG_SEL, OFS_REP_CNT, OFS_REP_RLD, OFS_QUAD_DIR};
		foreach (a[i]) begin
			apb(1'b0, a[i], 32'h0, q, e);
			`CHK("reset value", RST_REG, q)
			`CHK("mapped no error", 1'b0, e)
		end
		apb(1'b0, 16'h1000, 32'h0, q, e);
		`CHK("unmapped error", 1'b1, e)
	endtask : t_reset

	// settle a few cycles so only the routing is judged
	task automatic trig_chk(input logic [17:0] v, input logic x);
		far.set_lines(v);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		`CHK("counter trigger", x, counter_trig)
	endtask : trig_chk

	task automatic t_trig;
		apb(1'b1, OFS_TRIG_SEL, 32'hFFFFFFFF, q, e);
		apb(1'b0, OFS_TRIG_SEL, 32'h0, q, e);
		`CHK("select readback", 32'h0000021F, q)
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, OFS_TRIG_SEL, 32'h200 | c, q, e);
			trig_chk(c < 18 ? 18'h1 << c : 18'h3FFFF, c < 18);
			trig_chk(~(18'h1 << c), 1'b0);
		end
		apb(1'b1, OFS_TRIG_SEL, 32'h5, q, e);
		trig_chk(18'h3FFFF, 1'b0);
	endtask : t_trig

	task automatic t_repeat;
		logic [7:0] cnt [4] = '{8'h02, 8'h01, 8'h00, 8'h02};
		apb(1'b1, OFS_REP_RLD, 32'hFFFFFFFF, q, e);
		apb(1'b0, OFS_REP_RLD, 32'h0, q, e);
		`CHK("reload width", 32'h000000FF, q)
		apb(1'b1, OFS_REP_RLD, 32'h2, q, e);
		for (int i = 0; i < 4; i++) begin
			far.pulse_evt(6'h3F);
			@(negedge pclk);
			`CHK("event out", (i == 0 || i == 3) ? 6'h3F : 6'h00, evt_out)
			apb(1'b0, OFS_REP_CNT, 32'h0, q, e);
			`CHK("repeat count", {24'h0, cnt[i]}, q)
		end
		apb(1'b1, OFS_REP_CNT, 32'h77, q, e);
		apb(1'b0, OFS_REP_CNT, 32'h0, q, e);
		`CHK("count read only", 32'h2, q)
	endtask : t_repeat

	// one full encoder cycle, phase a leading when up is set
	task automatic dir_seq(input logic m, input logic up, input logic x);
		@(posedge pclk);
		quadrature_decoder_mode <= m;
		for (int i = 0; i < 4; i++) begin
			far.step(up ? i < 2 : i == 1 || i == 2, up ? i == 1 || i == 2 : i < 2);
		end
		@(negedge pclk);
		`CHK("direction", x, quadrature_direction)
		apb(1'b0, OFS_QUAD_DIR, 32'h0, q, e);
		`CHK("direction register", {31'h0, x}, q)
	endtask : dir_seq

	// main sequence: reset held 8 cycles, then the scenarios
	initial begin
		{presetn, psel, penable, pwrite, quadrature_decoder_mode} = 5'b00000;
		paddr = 16'h0000;
		pwdata = 32'h0;
		n_mismatch = 0;
		compares = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_trig;
		t_repeat;
		dir_seq(1'b1, 1'b1, 1'b1);
		dir_seq(1'b0, 1'b0, 1'b1);
		dir_seq(1'b1, 1'b0, 1'b0);
		stop_test;
	end

	// watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		stop_test;
	end
endmodule : tb_top
